/* hdl/imu_pkg.sv */
// Purpose: Shared constants, types and state layouts of the IMU command and ID registers
// Assumes: 25 MHz system clock, 16-bit registers at byte address pairs
// Notes:   Durations without a printed figure are plain defaults
package imu_pkg;
   localparam logic [6:0]  ADDR_BIAS_CFG   = 7'h66;
   localparam logic [6:0]  ADDR_GLOBAL_CMD = 7'h68;
   localparam logic [6:0]  ADDR_FW_VER     = 7'h6c;
   localparam logic [6:0]  ADDR_MONTH_DAY  = 7'h6e;
   localparam logic [6:0]  ADDR_YEAR       = 7'h70;
   localparam logic [6:0]  ADDR_PRODUCT    = 7'h72;
   localparam logic [6:0]  ADDR_SERIAL     = 7'h74;
   localparam logic [6:0]  ADDR_SCR_ONE    = 7'h76;
   localparam logic [6:0]  ADDR_SCR_TWO    = 7'h78;

   localparam logic [15:0] CFG_RESET       = 16'h070a;
   localparam logic [15:0] CFG_MASK        = 16'h3f0f;
   localparam logic [3:0]  TBC_MAX         = 4'hc;
   localparam int          CFG_GYRO_LSB    = 8;
   localparam int          CFG_ACCEL_LSB   = 11;

   localparam logic [7:0]  CMD_MASK         = 8'h9f;
   localparam logic [2:0]  CMD_SW_RESET     = 3'h7;
   localparam logic [2:0]  CMD_FLASH_TEST   = 3'h4;
   localparam logic [2:0]  CMD_FLASH_UPDATE = 3'h3;
   localparam logic [2:0]  CMD_SELF_TEST    = 3'h2;
   localparam logic [2:0]  CMD_FACTORY      = 3'h1;
   localparam logic [2:0]  CMD_BIAS_UPDATE  = 3'h0;

   localparam int          CLK_HZ          = 25_000_000;
   localparam int          TB_BASE_HZ      = 2000;
   localparam int          TB_UNIT_CYCLES  = CLK_HZ / TB_BASE_HZ;
   localparam int          AVG_TB_COUNT    = 64;
   localparam int          RESET_TIME_US   = 100;
   localparam logic [11:0] RESET_RESTART_CYCLES = 12'(RESET_TIME_US * (CLK_HZ / 1_000_000));
   localparam logic [11:0] CMD_SHORT_CYCLES = 12'h010;
   localparam int          ST_SETTLE_US    = 50;
   localparam logic [10:0] ST_SETTLE_CYCLES = 11'(ST_SETTLE_US * (CLK_HZ / 1_000_000));
   localparam logic [15:0] ST_LIMIT_LO     = 16'h0100;
   localparam logic [15:0] ST_LIMIT_HI     = 16'h4000;
   localparam int          AXES            = 6;

   typedef enum logic [1:0] {IMU_IDLE, IMU_TIMED, IMU_FLASH, IMU_SELF} imu_exec_t;
   typedef enum logic [2:0] {ST_IDLE, ST_MEAS_OFF, ST_SETTLE, ST_MEAS_ON, ST_JUDGE} imu_st_phase_t;

   typedef struct packed {
      imu_exec_t   ex;
      logic [15:0] cfg;
      logic [15:0] scr1;
      logic [15:0] scr2;
      logic [7:0]  pend;
      logic        flash_op;
      logic [11:0] cnt;
      logic [15:0] resp;
      logic        resp_v;
      logic        sw_rst;
      logic        fac;
      logic        bias;
      logic        st_go;
      logic        tb_restart;
      logic        crc_fail;
      logic        st_fail;
      logic        upd_fail;
   } imu_regs_t;

   typedef struct packed {
      imu_st_phase_t ph;
      logic [95:0]   base;
      logic [10:0]   cnt;
      logic [5:0]    ok;
      logic          stim;
      logic          done;
      logic          fail;
   } imu_st_state_t;

   typedef struct packed {
      logic [25:0] cnt;
      logic [5:0]  ticks;
      logic        tick;
      logic        avg;
   } imu_tb_state_t;
endpackage

/* hdl/imu_st_if.sv */
// Purpose: Start and result handshake between the register bank and the self test engine
// Assumes: Both ends on sys_clk
// Notes:   start and done are one-cycle pulses, fail is valid with done
interface imu_st_if;
   logic start;
   logic done;
   logic fail;
   modport ctl (output start, input done, input fail);
   modport eng (input start, output done, output fail);
endinterface

/* hdl/imu_timebase.sv */
// Purpose: Bias estimator time base ticks and averaging window completion
// Assumes: tbc already limited to 0..12
// Notes:   Period is the unit count shifted left by tbc
module imu_timebase
   import imu_pkg::*;
#(
   parameter int unsigned TB_UNIT = TB_UNIT_CYCLES
)
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       restart,
   input  wire logic [3:0] time_base_field,
   output logic            tb_tick,
   output logic            avg_done
);
   imu_tb_state_t s_reg;
   imu_tb_state_t s_next;
   logic [25:0]   period;

   assign period = 26'(TB_UNIT << time_base_field);

   always_comb
   begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      s_next.avg = 1'b0;
      if (restart)
      begin
         s_next.cnt = '0;
         s_next.ticks = '0;
      end
      else if (s_reg.cnt >= period - 26'h1)
      begin
         // Compare, not equality: a shorter base chosen mid-count must not run away
         s_next.cnt = '0;
         s_next.tick = 1'b1;
         s_next.ticks = s_reg.ticks + 6'h1;
         s_next.avg = (s_reg.ticks == 6'(AVG_TB_COUNT - 1));
      end
      else
      begin
         s_next.cnt = s_reg.cnt + 26'h1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign tb_tick = s_reg.tick;
   assign avg_done = s_reg.avg;

   a_avg_on_tick: assert property (@(posedge sys_clk) disable iff (rst)
      avg_done |-> tb_tick) else $error("Average window ended off a time base tick");
   a_tick_single: assert property (@(posedge sys_clk) disable iff (rst)
      tb_tick && !restart |=> !tb_tick) else $error("Time base ticks back to back");
endmodule

/* hdl/imu_selftest.sv */
// Purpose: Sensor self test: measure, stimulate, measure, release, judge
// Assumes: sensor_valid pulses with a fresh six-axis sample on sys_clk
// Notes:   Motion during the test can fail it falsely
module imu_selftest
   import imu_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   imu_st_if.eng            st,
   input  wire logic        sensor_valid,
   input  wire logic [95:0] sensor_sample,
   output logic             stimulus_on
);
   imu_st_state_t s_reg;
   imu_st_state_t s_next;
   logic [5:0]    pass;

   for (genvar i = 0; i < AXES; i++)
   begin : g_axis
      logic signed [16:0] diff;
      logic [16:0]        mag;
      assign diff = $signed({sensor_sample[i*16+15], sensor_sample[i*16+:16]})
                  - $signed({s_reg.base[i*16+15], s_reg.base[i*16+:16]});
      assign mag = diff[16] ? 17'(-diff) : 17'(diff);
      assign pass[i] = (mag >= {1'b0, ST_LIMIT_LO}) && (mag <= {1'b0, ST_LIMIT_HI});
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.done = 1'b0;
      unique case (s_reg.ph)
         ST_IDLE:
            if (st.start)
               s_next.ph = ST_MEAS_OFF;
         ST_MEAS_OFF:
            if (sensor_valid)
            begin
               s_next.base = sensor_sample;
               s_next.stim = 1'b1;
               s_next.cnt = ST_SETTLE_CYCLES;
               s_next.ph = ST_SETTLE;
            end
         ST_SETTLE:
            // Response needs time to settle before the second measurement
            if (s_reg.cnt == 11'h0)
               s_next.ph = ST_MEAS_ON;
            else
               s_next.cnt = s_reg.cnt - 11'h1;
         ST_MEAS_ON:
            if (sensor_valid)
            begin
               s_next.ok = pass;
               s_next.stim = 1'b0;
               s_next.ph = ST_JUDGE;
            end
         ST_JUDGE:
         begin
            s_next.done = 1'b1;
            s_next.fail = ~&s_reg.ok;
            s_next.ph = ST_IDLE;
         end
         default:
            s_next.ph = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign stimulus_on = s_reg.stim;
   assign st.done = s_reg.done;
   assign st.fail = s_reg.fail;

   a_stim_released: assert property (@(posedge sys_clk) disable iff (rst)
      st.done |-> !stimulus_on && $past(!stimulus_on)) else $error("Result before stimulus off");
   a_stim_after_meas: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(stimulus_on) |-> $past(sensor_valid)) else $error("Stimulus before first measure");
endmodule

/* hdl/imu_cmd_regs.sv */
// Purpose: Bias estimator configuration, global command triggers and ID registers
// Assumes: Serial words already assembled: bit 15 write flag, 14:8 address, 7:0 data
// Notes:   A read word answers in the next cycle; words are dropped while busy
module imu_cmd_regs
   import imu_pkg::*;
#(
   parameter logic [15:0] PRODUCT_CODE     = 16'h5a5a, // Arbitrary value
   parameter logic [15:0] FW_VERSION       = 16'h0100,
   parameter logic [15:0] CONFIG_MONTH_DAY = 16'h0101,
   parameter logic [15:0] CONFIG_YEAR      = 16'h2000,
   parameter logic [15:0] LOT_SERIAL       = 16'h0001,
   parameter int unsigned TB_UNIT          = TB_UNIT_CYCLES
)
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        word_valid,
   input  wire logic [15:0] word_in,
   output logic [15:0]      resp_word,
   output logic             resp_valid,
   output logic             cmd_busy,
   output logic             data_run,
   output logic             sw_reset_pulse,
   output logic             factory_restore_pulse,
   output logic             bias_update_pulse,
   output logic [2:0]       gyro_bias_en,
   output logic [2:0]       accel_bias_en,
   output logic             time_base_tick,
   output logic             avg_window_done,
   output logic             flash_req,
   output logic             flash_op,
   input  wire logic        flash_done,
   input  wire logic        flash_fail,
   output logic [47:0]      backup_image,
   input  wire logic        sensor_valid,
   input  wire logic [95:0] sensor_sample,
   output logic             stimulus_on,
   output logic             diag_crc_fail,
   output logic             diag_self_test_fail,
   output logic             diag_update_fail
);
   imu_regs_t   s_reg;
   imu_regs_t   s_next;
   imu_st_if    st_bus ();
   logic [6:0]  wr_addr;
   logic [6:0]  pair_addr;
   logic        hi_byte;
   logic [7:0]  wr_data;
   logic [15:0] rd_data;
   logic [2:0]  pick;

   assign wr_addr = word_in[14:8];
   assign pair_addr = {word_in[14:9], 1'b0};
   assign hi_byte = word_in[8];
   assign wr_data = word_in[7:0];

   // Highest set trigger bit runs first, so a reset overrides everything queued
   function automatic logic [2:0] top_bit(input logic [7:0] p);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 8; i++)
      begin
         if (p[i])
            r = 3'(i);
      end
      return r;
   endfunction

   function automatic logic [15:0] put_byte(input logic [15:0] old, input logic hi,
                                            input logic [7:0] d);
      return hi ? {d, old[7:0]} : {old[15:8], d};
   endfunction

   // Read side of every register pair
   always_comb
   begin
      unique case (pair_addr)
         ADDR_BIAS_CFG:   rd_data = s_reg.cfg;
         ADDR_GLOBAL_CMD: rd_data = 16'h0000;
         ADDR_FW_VER:     rd_data = FW_VERSION;
         ADDR_MONTH_DAY:  rd_data = CONFIG_MONTH_DAY;
         ADDR_YEAR:       rd_data = CONFIG_YEAR;
         ADDR_PRODUCT:    rd_data = PRODUCT_CODE;
         ADDR_SERIAL:     rd_data = LOT_SERIAL;
         ADDR_SCR_ONE:    rd_data = s_reg.scr1;
         ADDR_SCR_TWO:    rd_data = s_reg.scr2;
         default:         rd_data = 16'h0000;
      endcase
   end

   assign pick = top_bit(s_reg.pend);

   always_comb
   begin
      logic [15:0] cfg_new;
      cfg_new = s_reg.cfg;
      s_next = s_reg;
      s_next.resp_v = 1'b0;
      s_next.sw_rst = 1'b0;
      s_next.fac = 1'b0;
      s_next.bias = 1'b0;
      s_next.st_go = 1'b0;
      s_next.tb_restart = 1'b0;
      unique case (s_reg.ex)
         IMU_IDLE:
         begin
            if (s_reg.pend != 8'h00)
            begin
               s_next.pend[pick] = 1'b0;
               if (pick == CMD_SW_RESET)
               begin
                  // Config and scratch back to reset values, queued triggers die too; diagnostic flags keep their values
                  s_next.cfg = CFG_RESET;
                  s_next.scr1 = 16'h0000;
                  s_next.scr2 = 16'h0000;
                  s_next.pend = 8'h00;
                  s_next.sw_rst = 1'b1;
                  s_next.tb_restart = 1'b1;
                  s_next.cnt = RESET_RESTART_CYCLES;
                  s_next.ex = IMU_TIMED;
               end
               else if (pick == CMD_FLASH_TEST || pick == CMD_FLASH_UPDATE)
               begin
                  s_next.flash_op = (pick == CMD_FLASH_UPDATE);
                  s_next.ex = IMU_FLASH;
               end
               else if (pick == CMD_SELF_TEST)
               begin
                  s_next.st_go = 1'b1;
                  s_next.ex = IMU_SELF;
               end
               else
               begin
                  s_next.fac = (pick == CMD_FACTORY);
                  s_next.bias = (pick == CMD_BIAS_UPDATE);
                  s_next.cnt = CMD_SHORT_CYCLES;
                  s_next.ex = IMU_TIMED;
               end
            end
            else if (word_valid && word_in[15])
            begin
               unique case (pair_addr)
                  ADDR_BIAS_CFG:
                  begin
                     cfg_new = put_byte(s_reg.cfg, hi_byte, wr_data) & CFG_MASK;
                     if (cfg_new[3:0] > TBC_MAX)
                        cfg_new[3:0] = TBC_MAX;
                     s_next.cfg = cfg_new;
                     s_next.tb_restart = (cfg_new[3:0] != s_reg.cfg[3:0]);
                  end
                  ADDR_GLOBAL_CMD:
                     // High byte holds no triggers; the zero write that follows is harmless
                     if (!hi_byte)
                        s_next.pend = wr_data & CMD_MASK;
                  ADDR_SCR_ONE:
                     s_next.scr1 = put_byte(s_reg.scr1, hi_byte, wr_data);
                  ADDR_SCR_TWO:
                     s_next.scr2 = put_byte(s_reg.scr2, hi_byte, wr_data);
                  default:
                     s_next.pend = s_reg.pend;
               endcase
            end
            else if (word_valid)
            begin
               s_next.resp = rd_data;
               s_next.resp_v = 1'b1;
            end
         end
         IMU_TIMED:
         begin
            if (s_reg.cnt <= 12'h001)
               s_next.ex = IMU_IDLE;
            else
               s_next.cnt = s_reg.cnt - 12'h001;
         end
         IMU_FLASH:
         begin
            if (flash_done)
            begin
               if (s_reg.flash_op)
                  s_next.upd_fail = flash_fail;
               else
                  s_next.crc_fail = flash_fail;
               s_next.ex = IMU_IDLE;
            end
         end
         IMU_SELF:
         begin
            if (st_bus.done)
            begin
               s_next.st_fail = st_bus.fail;
               s_next.ex = IMU_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.cfg <= CFG_RESET;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign st_bus.start = s_reg.st_go;

   imu_selftest u_selftest (
      .sys_clk       (sys_clk),
      .rst           (rst),
      .st            (st_bus.eng),
      .sensor_valid  (sensor_valid),
      .sensor_sample (sensor_sample),
      .stimulus_on   (stimulus_on)
   );

   imu_timebase #(
      .TB_UNIT (TB_UNIT)
   ) u_timebase (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .restart  (s_reg.tb_restart),
      .time_base_field      (s_reg.cfg[3:0]),
      .tb_tick  (time_base_tick),
      .avg_done (avg_window_done)
   );

   // A queued trigger counts as busy so no word slips in before it starts
   assign cmd_busy = (s_reg.ex != IMU_IDLE) || (s_reg.pend != 8'h00);
   assign data_run = !cmd_busy;
   assign resp_word = s_reg.resp;
   assign resp_valid = s_reg.resp_v;
   assign sw_reset_pulse = s_reg.sw_rst;
   assign factory_restore_pulse = s_reg.fac;
   assign bias_update_pulse = s_reg.bias;
   assign gyro_bias_en = s_reg.cfg[CFG_GYRO_LSB+:3];
   assign accel_bias_en = s_reg.cfg[CFG_ACCEL_LSB+:3];
   assign flash_req = (s_reg.ex == IMU_FLASH);
   assign flash_op = s_reg.flash_op;
   // Serial number stays out of the image, it is not user data
   assign backup_image = {s_reg.cfg, s_reg.scr1, s_reg.scr2};
   assign diag_crc_fail = s_reg.crc_fail;
   assign diag_self_test_fail = s_reg.st_fail;
   assign diag_update_fail = s_reg.upd_fail;

   a_cfg_after_reset: assert property (@(posedge sys_clk)
      $fell(rst) |-> s_reg.cfg == 16'h070a) else $error("Config not 0x070a after reset");
   a_busy_ignores: assert property (@(posedge sys_clk) disable iff (rst)
      cmd_busy && word_valid |=> !resp_valid
      && ($stable(s_reg.scr1) || sw_reset_pulse) && ($stable(s_reg.cfg) || sw_reset_pulse))
      else $error("Serial word served while busy");
   a_cmd_reads_zero: assert property (@(posedge sys_clk) disable iff (rst)
      word_valid && !cmd_busy && !word_in[15] && pair_addr == ADDR_GLOBAL_CMD
      |=> resp_valid && resp_word == 16'h0000) else $error("Command register readable");
   a_product_fixed: assert property (@(posedge sys_clk) disable iff (rst)
      word_valid && !cmd_busy && !word_in[15] && wr_addr[6:1] == ADDR_PRODUCT[6:1]
      |=> resp_word == PRODUCT_CODE) else $error("Product code read wrong");
   a_unused_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (s_reg.cfg & ~CFG_MASK) == 16'h0000 && s_reg.cfg[3:0] <= 4'hc)
      else $error("Unused config bits set or time base out of range");
   a_soft_reset: assert property (@(posedge sys_clk) disable iff (rst)
      sw_reset_pulse |-> s_reg.cfg == CFG_RESET && cmd_busy ##1 cmd_busy [*8])
      else $error("Software reset did not restore and hold busy");
   a_flash_result: assert property (@(posedge sys_clk) disable iff (rst)
      flash_req && flash_done && !flash_op |=> diag_crc_fail == $past(flash_fail) && !flash_req)
      else $error("Flash check result not reported");
endmodule

/* testbench/imu_far_model.sv */
// Purpose: Flash and sensor responder beside the command registers
// Assumes: Everything on sys_clk
// Notes:   Sample bus shows a changing pattern between valid pulses
module imu_far_model
   import imu_pkg::*;
(
   input  wire logic   sys_clk,
   input  wire logic   flash_req,
   input  wire logic   fail_en,
   input  wire logic   st_bad,
   input  wire logic   stimulus_on,
   output logic        flash_done,
   output logic        flash_fail,
   output logic        sensor_valid,
   output logic [95:0] sensor_sample
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]  cnt = 4'h0;
   logic [15:0] d;
   // Small step fails the window, large step passes
   assign d = st_bad ? 16'h0010 : 16'h0200;
   initial
   begin
      flash_done = 1'b0;
      flash_fail = 1'b0;
      sensor_valid = 1'b0;
      sensor_sample = '0;
   end
   always @(posedge sys_clk)
   begin
      cnt <= cnt + 4'h1;
      flash_done <= flash_req && cnt == 4'he;
      flash_fail <= (flash_req && cnt == 4'he) ? fail_en : ~fail_en;
      sensor_valid <= cnt[2:0] == 3'h7;
      if (cnt[2:0] == 3'h7)
         sensor_sample <= stimulus_on ? {6{d}} : 96'h0;
      else
         sensor_sample <= {24{cnt}};
   end
endmodule

/* testbench/tb_imu_cmd_regs.sv */
// Purpose: Self-checking bench of the command and ID registers
// Assumes: Time base unit shrunk to 4 cycles
// Notes:   Register model kept in ints beside the design
`define CK(nm, e, v) begin checks_done++; if ((v) !== (e)) begin err_total++; \
   $display("Error %s exp %h got %h", nm, e, v); end end
module tb_imu_cmd_regs
   import imu_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] PC = 16'h3c3c; // Arbitrary value
   logic        sys_clk = 1'b0, rst = 1'b1, word_valid = 1'b0, fail_en = 1'b0, st_bad = 1'b0;
   logic [15:0] word_in = 16'h0000, resp_word;
   logic        resp_valid, cmd_busy, data_run, sw_reset_pulse, factory_restore_pulse;
   logic        bias_update_pulse, time_base_tick, avg_window_done, flash_req, flash_op;
   logic        flash_done, flash_fail, sensor_valid, stimulus_on;
   logic        diag_crc_fail, diag_self_test_fail, diag_update_fail;
   logic [2:0]  gyro_bias_en, accel_bias_en;
   logic [47:0] backup_image;
   logic [95:0] sensor_sample;
   logic [31:0] r;
   logic        got = 1'b0;
   logic [15:0] got_w = 16'h0000;
   int          err_total = 0, checks_done = 0, cyc = 0, nb = 0, nf = 0, ns = 0, n;
   int          cfg_m = 'h070a, s1_m = 0, s2_m = 0;

   imu_cmd_regs #(.PRODUCT_CODE(PC), .TB_UNIT(4)) u_imu_cmd_regs (.sys_clk, .rst,
      .word_valid, .word_in, .resp_word, .resp_valid, .cmd_busy, .data_run, .sw_reset_pulse,
      .factory_restore_pulse, .bias_update_pulse, .gyro_bias_en, .accel_bias_en,
      .time_base_tick, .avg_window_done, .flash_req, .flash_op, .flash_done, .flash_fail,
      .backup_image, .sensor_valid, .sensor_sample, .stimulus_on, .diag_crc_fail,
      .diag_self_test_fail, .diag_update_fail);
   imu_far_model u_imu_far_model (.sys_clk, .flash_req, .fail_en, .st_bad, .stimulus_on,
      .flash_done, .flash_fail, .sensor_valid, .sensor_sample);

   always #20 sys_clk = ~sys_clk;

   task summarize;
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (bias_update_pulse === 1'b1) nb++;
      if (factory_restore_pulse === 1'b1) nf++;
      if (sw_reset_pulse === 1'b1) ns++;
      // Answer stands one cycle only; catch it at the edge where it is high
      if (resp_valid === 1'b1)
      begin
         got = 1'b1;
         got_w = resp_word;
      end
      if (cyc == 20000)
      begin
         err_total++;
         summarize;
      end
   end

   task tk;
      @(posedge sys_clk);
      #1;
   endtask
   task send(input logic [15:0] w);
      word_in = w;
      word_valid = 1'b1;
      tk;
      word_valid = 1'b0;
      // Let one edge pass so the next word never re-raises valid in the same step
      tk;
   endtask
   function int mrg(int o, logic h, logic [7:0] d);
      return h ? (o & 'hff) | (d << 8) : (o & 'hff00) | d;
   endfunction
   // Model follows only words the design is allowed to take
   task wr(input logic [6:0] a, input logic [7:0] d);
      send({1'b1, a, d});
      case (a)
         7'h66: cfg_m = (cfg_m & 'h3f00) | (d[3:0] > 4'hc ? 12 : d[3:0]);
         7'h67: cfg_m = (cfg_m & 'hf) | ((d & 8'h3f) << 8);
         7'h76, 7'h77: s1_m = mrg(s1_m, a[0], d);
         7'h78, 7'h79: s2_m = mrg(s2_m, a[0], d);
         default: ;
      endcase
   endtask
   function int exp_rd(logic [6:0] a);
      case (a)
         7'h66: return cfg_m;
         7'h6c: return 'h0100;
         7'h6e: return 'h0101;
         7'h70: return 'h2000;
         7'h72: return PC;
         7'h74: return 'h0001;
         7'h76: return s1_m;
         7'h78: return s2_m;
         default: return 0;
      endcase
   endfunction
   task rd(input logic [6:0] a);
      got = 1'b0;
      send({1'b0, a, 8'h00});
      `CK("resp_valid", 1'b1, got)
      `CK("resp_word", exp_rd(a), got_w)
   endtask
   task cmd(input logic [7:0] b);
      wr(7'h68, b);
      send(16'he900);
   endtask
   task idle;
      n = 0;
      while (cmd_busy !== 1'b0 && n < 4000)
      begin
         tk;
         n++;
      end
      `CK("cmd_busy", 1'b0, cmd_busy)
   endtask
   task gap(input bit s, output int c);
      c = 0;
      do
      begin
         tk;
         c++;
      end while ((s ? avg_window_done : time_base_tick) !== 1'b1 && c < 2000);
   endtask

   initial
   begin
      void'($urandom(32'h4c44eeac));
      repeat (4) tk;
      rst = 1'b0;
      `CK("gyro_en", 3'h7, gyro_bias_en)
      `CK("accel_en", 3'h0, accel_bias_en)
      wr(7'h72, 8'hff);
      for (int a = 'h66; a <= 'h7a; a += 2) rd(7'(a));
      wr(7'h66, 8'hff);
      rd(7'h66);
      repeat (8)
      begin
         r = $urandom;
         wr(7'h66, r[7:0]);
         wr(7'h67, r[15:8]);
         wr(7'h76, r[23:16]);
         wr(7'h79, r[31:24]);
         rd(7'h66);
         rd(7'h76);
         rd(7'h78);
         `CK("gyro_en", 3'(cfg_m >> 8), gyro_bias_en)
         `CK("accel_en", 3'(cfg_m >> 11), accel_bias_en)
      end
      wr(7'h67, 8'h07);
      wr(7'h66, 8'h01);
      gap(0, n);
      gap(0, n);
      `CK("tick_gap", 4 << 1, n)
      gap(1, n);
      gap(1, n);
      `CK("avg_gap", 64 * (4 << 1), n)
      cmd(8'h01);
      `CK("busy", 1'b1, cmd_busy)
      `CK("data_run", 1'b0, data_run)
      send(16'hf655);
      idle;
      rd(7'h76);
      `CK("bias_pulses", 1, nb)
      cmd(8'h03);
      idle;
      `CK("bias_pulses", 2, nb)
      `CK("restore_pulses", 1, nf)
      for (int k = 0; k < 4; k++)
      begin
         fail_en = k[0];
         st_bad = k[0];
         cmd(k[1] ? 8'h08 : 8'h10);
         idle;
         if (k[1])
         begin
            `CK("upd_fail", k[0], diag_update_fail)
            `CK("backup", {cfg_m[15:0], s1_m[15:0], s2_m[15:0]}, backup_image)
         end
         else
            `CK("crc_fail", k[0], diag_crc_fail)
         cmd(8'h04);
         idle;
         `CK("st_fail", k[0], diag_self_test_fail)
      end
      cmd(8'h80);
      idle;
      `CK("reset_pulses", 1, ns)
      cfg_m = 'h070a;
      s1_m = 0;
      s2_m = 0;
      rd(7'h66);
      rd(7'h76);
      `CK("gyro_en", 3'h7, gyro_bias_en)
      summarize;
   end
endmodule
